// ===== line_glitch_filter.sv
// Synchroniser and high/low glitch filter for the shared bus line.
// Assumes the line arrives asynchronously and a one-clock sampling tick.
`timescale 1ns/10ps
module line_glitch_filter
   import rx_timing_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic line_in,
   input wire logic tick,
   input wire logic [1:0] high_len,
   input wire logic [2:0] low_len,
   output line_s line
);

   // ==========================================================
   // Three-stage synchroniser; a change counts once stages two and three agree
   logic sync1;
   logic sync2;
   logic sync3;
   logic stable;
   logic run_level;
   logic [2:0] run_len;
   logic [2:0] low_need;
   logic [3:0] seen;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sync1 <= 1'b1;
         sync2 <= 1'b1;
         sync3 <= 1'b1;
      end
      else
      begin
         sync1 <= line_in;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   // Stable sampled level, held while the last two stages disagree
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         stable <= 1'b1;
      else if (sync2 == sync3)
         stable <= sync3;
   end

   // Reserved low codes act as the longest legal filter
   assign low_need = (low_len > MAX_FILTER_CODE) ? MAX_FILTER_CODE : low_len;

   // Equal samples before this tick's one; code n asks for n of them, n+1 in all
   assign seen = (stable == run_level) ? {1'b0, run_len} + 4'h1 : 4'h0;

   // Count consecutive equal samples at each tick
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         run_level <= 1'b1;
         run_len <= 3'h0;
      end
      else if (tick)
      begin
         run_level <= stable;
         if (stable != run_level)
            run_len <= 3'h0;
         else if (run_len != 3'h7)
            run_len <= run_len + 3'h1;
      end
   end

   // Level changes only after enough samples; a shorter run is noise
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         line.level <= 1'b1;
         line.fall <= 1'b0;
      end
      else
      begin
         line.fall <= 1'b0;
         if (tick)
         begin
            if (stable && !line.level && seen >= {2'b00, high_len}) // [R3]
               line.level <= 1'b1;
            if (!stable && line.level && seen >= {1'b0, low_need}) // [R4]
            begin
               line.level <= 1'b0;
               line.fall <= 1'b1; // [R12]
            end
         end
      end
   end

endmodule

// ===== line_peer.sv
// Shared bus line with its pull-up, as the other devices on it see it.
// Assumes the block pulls the line low through line_oe with line_out at 0.
`timescale 1ns/10ps
module line_peer #(
   parameter int RISE = 2
)
(
   input wire logic hclk,
   input wire logic line_oe,
   input wire logic line_out,
   input wire logic pull_low,
   output logic line_level
);
   // ==========================================================
   // Wired-AND line
   logic low_now;
   int rel = RISE;
   assign low_now = pull_low || (line_oe && !line_out);

   // Slow rise after release: the pull-up needs a few clocks to lift the line
   always_ff @(posedge hclk)
   begin
      if (low_now)
         rel <= 0;
      else if (rel < RISE)
         rel <= rel + 1;
   end
   assign line_level = !low_now && rel >= RISE;
endmodule

// ===== rx_timing_ctrl.sv
// Receive timing, glitch filtering and acknowledge logic for a single-wire control
// link, with its registers on an AHB-Lite slave port.
// Assumes one slave on the bus, an open-drain line resolved by the surroundings,
// and a separate start-bit detector that pulses frame_start.
//
// Summary of operation
// (R1) Data block acknowledge unless suppress bit set
// (R2) Header block matching own address always acknowledged; the code skips it while an error is held
// (R3) High level needs one to four samples
// (R4) Low level needs one to four samples
// (R5) Minimum cycle is 67 ticks plus adjust
// (R6) Short cycle: interrupt, drive line low 3.63ms
// (R7) Maximum cycle is 90 ticks plus adjust
// (R8) Long cycle raises an interrupt; the code raises none with error_irq_hold and timeout_cycles 0
// (R9) Data decision point 34 ticks, steps of two
// (R10) Hold errors until acknowledge or timeout
// (R11) Optionally receive blocks for foreign addresses
// (R12) Count ticks from filtered falling edge
//
// Design decisions made here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module rx_timing_ctrl
   import rx_timing_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic frame_start,
   input wire logic line_in,
   output logic line_out,
   output logic line_oe,
   output logic irq
);

   typedef enum logic [1:0] {st_idle, st_armed, st_bit, st_low_drive} rx_state_e;

   // ==========================================================
   // Threshold arithmetic
   function automatic logic [8:0] bit_limit(input logic [8:0] base, input logic [2:0] code);
      if (code[2])
         bit_limit = base - 9'({1'b0, code} - 4'h3);
      else
         bit_limit = base + 9'(code);
   endfunction

   function automatic logic [8:0] decision_ticks(input logic [2:0] code);
      case (code)
         3'h1: decision_ticks = DATA_BASE_TICKS + DATA_STEP_TICKS;
         3'h2: decision_ticks = DATA_BASE_TICKS + 9'(2 * DATA_STEP_TICKS);
         3'h3: decision_ticks = DATA_BASE_TICKS + 9'(3 * DATA_STEP_TICKS);
         3'h4: decision_ticks = DATA_BASE_TICKS - DATA_STEP_TICKS;
         3'h5: decision_ticks = DATA_BASE_TICKS - 9'(2 * DATA_STEP_TICKS);
         3'h6: decision_ticks = DATA_BASE_TICKS - 9'(3 * DATA_STEP_TICKS);
         default: decision_ticks = DATA_BASE_TICKS;
      endcase
   endfunction

   // ==========================================================
   // Registers
   logic [31:0] ctrl_reg;
   logic [15:0] own_addr;
   logic [2:0] status;
   logic [2:0] mask;
   logic [9:0] rx_word;
   ctrl_s cfg;
   line_s line;

   logic wr_pend;
   logic [7:0] wr_addr;
   logic addr_phase;
   logic [2:0] ev_set;
   logic [31:0] rd_mux;

   assign cfg = unpack_ctrl(ctrl_reg);
   assign hreadyout = 1'b1; // Zero wait states, every access completes at once
   assign hresp = 1'b0;
   assign addr_phase = hsel && hready && htrans[1];

   // Read mux; unmapped addresses read as zero
   always_comb
   begin
      case (haddr[7:0])
         CTRL_ADDR: rd_mux = ctrl_reg;
         OWN_ADDR_ADDR: rd_mux = {16'h0000, own_addr};
         STATUS_ADDR: rd_mux = {29'h0, status};
         MASK_ADDR: rd_mux = {29'h0, mask};
         RXDATA_ADDR: rd_mux = {22'h0, rx_word};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // Address phase capture; read data is ready for the following data phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         hrdata <= 32'h0000_0000;
      end
      else
      begin
         wr_pend <= addr_phase && hwrite;
         if (addr_phase)
            wr_addr <= haddr[7:0];
         if (addr_phase && !hwrite)
            hrdata <= rd_mux;
      end
   end

   // Configuration registers; writes land in the data phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl_reg <= CTRL_RESET;
         own_addr <= OWN_ADDR_RESET;
         mask <= STATUS_RESET;
      end
      else if (wr_pend)
      begin
         if (wr_addr == CTRL_ADDR)
            ctrl_reg <= hwdata & CTRL_WMASK;
         if (wr_addr == OWN_ADDR_ADDR)
            own_addr <= hwdata[15:0];
         if (wr_addr == MASK_ADDR)
            mask <= hwdata[2:0];
      end
   end

   // Sticky status, write one to clear; a new event wins over the clear
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         status <= STATUS_RESET;
      else if (wr_pend && wr_addr == STATUS_ADDR)
         status <= (status & ~hwdata[2:0]) | ev_set;
      else
         status <= status | ev_set;
   end

   // Level interrupt while any unmasked status bit is set
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         irq <= 1'b0;
      else
         irq <= |(status & mask);
   end

   // ==========================================================
   // Sampling tick and line filter
   logic [9:0] tick_cnt;
   logic tick;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         tick_cnt <= 10'h000;
         tick <= 1'b0;
      end
      else
      begin
         tick <= (tick_cnt == TICK_DIV - 10'h001);
         tick_cnt <= (tick_cnt == TICK_DIV - 10'h001) ? 10'h000 : tick_cnt + 10'h001;
      end
   end

   line_glitch_filter filter_i (
      .hclk(hclk),
      .hresetn(hresetn),
      .line_in(line_in),
      .tick(tick),
      .high_len(cfg.high_glitch_filter_len),
      .low_len(cfg.low_glitch_filter_len),
      .line(line)
   );

   // ==========================================================
   // Bit timing state machine
   rx_state_e state;
   logic [8:0] cnt;
   logic [3:0] bit_idx;
   logic header_blk;
   logic [9:0] shift;
   logic addr_match;
   logic receiving;
   logic ack_want;
   logic ack_drive;
   logic err_pending;
   logic [8:0] min_thr;
   logic [8:0] max_thr;
   logic [8:0] dec_thr;
   logic [8:0] tout_thr;
   logic at_decision;
   logic dest_hit;
   logic dest_mine;

   assign min_thr = bit_limit(MIN_BASE_TICKS, cfg.min_bit_cycle_adjust); // [R5]
   assign max_thr = bit_limit(MAX_BASE_TICKS, cfg.max_bit_cycle_adjust); // [R7]
   assign dec_thr = decision_ticks(cfg.data_decision_point); // [R9]
   // Timeout spans one to three maximum bit cycles; the reserved code acts as three
   assign tout_thr = (cfg.timeout_cycles == 2'h0) ? max_thr :
                     (cfg.timeout_cycles == 2'h1) ? 9'(2 * max_thr) : 9'(3 * max_thr);
   assign at_decision = tick && state == st_bit && cnt == dec_thr;
   assign dest_mine = own_addr[shift[3:0]];
   assign dest_hit = dest_mine || shift[3:0] == 4'hf || cfg.foreign_address_receive; // [R11]

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state <= st_idle;
         cnt <= 9'h000;
         bit_idx <= 4'h0;
         header_blk <= 1'b1;
         shift <= 10'h000;
         addr_match <= 1'b0;
         receiving <= 1'b0;
         ack_want <= 1'b0;
         ack_drive <= 1'b0;
         err_pending <= 1'b0;
         rx_word <= 10'h000;
         ev_set <= 3'h0;
      end
      else
      begin
         ev_set <= 3'h0;
         case (state)
            st_idle:
            begin
               ack_drive <= 1'b0;
               if (frame_start)
               begin
                  state <= st_armed;
                  header_blk <= 1'b1;
                  bit_idx <= 4'h0;
                  err_pending <= 1'b0;
               end
            end
            st_armed:
            begin
               if (line.fall)
               begin
                  state <= st_bit;
                  cnt <= 9'h000;
               end
            end
            st_bit:
            begin
               if (line.fall && !ack_drive)
               begin
                  cnt <= 9'h000; // [R12]
                  if (cnt < min_thr) // [R6]
                  begin
                     ev_set[ST_MIN_ERR] <= 1'b1;
                     state <= st_low_drive;
                  end
                  else if (bit_idx == LAST_BIT)
                  begin
                     bit_idx <= 4'h0;
                     header_blk <= 1'b0;
                  end
                  else
                  begin
                     bit_idx <= bit_idx + 4'h1;
                     // Own drive stands in for the acknowledge bit's low phase
                     if (bit_idx == EOM_BIT && ack_want && !err_pending) // [R10]
                        ack_drive <= 1'b1;
                  end
               end
               else if (tick)
               begin
                  cnt <= cnt + 9'h001;
                  if (cnt == max_thr + 9'h001) // [R8]
                  begin
                     if (cfg.error_irq_hold)
                        err_pending <= 1'b1; // [R10]
                     else
                     begin
                        ev_set[ST_MAX_ERR] <= 1'b1;
                        state <= st_idle;
                     end
                  end
                  if (cfg.error_irq_hold && cnt == tout_thr) // [R10]
                  begin
                     ev_set[ST_MAX_ERR] <= err_pending;
                     state <= st_idle;
                  end
               end
               if (at_decision)
               begin
                  shift <= {shift[8:0], line.level};
                  if (bit_idx == LAST_BIT)
                     ack_drive <= 1'b0;
               end
               // Address decode at the end of the header byte
               if (at_decision && header_blk && bit_idx == BYTE_BIT)
               begin
                  addr_match <= own_addr[{shift[2:0], line.level}];
                  receiving <= own_addr[{shift[2:0], line.level}] ||
                               {shift[2:0], line.level} == 4'hf ||
                               cfg.foreign_address_receive; // [R11]
               end
               // Acknowledge decision once the end-of-message bit is in
               if (at_decision && bit_idx == EOM_BIT)
                  ack_want <= header_blk ? addr_match : // [R2]
                              (addr_match && !cfg.data_ack_suppress); // [R1]
               if (at_decision && bit_idx == LAST_BIT)
               begin
                  if (receiving)
                  begin
                     rx_word <= {line.level, shift[0], shift[8:1]};
                     ev_set[ST_RX_BYTE] <= 1'b1;
                  end
                  if (err_pending) // [R10]
                  begin
                     ev_set[ST_MAX_ERR] <= 1'b1;
                     err_pending <= 1'b0;
                  end
                  if (shift[0])
                     state <= st_idle;
               end
            end
            st_low_drive:
            begin
               ack_drive <= 1'b0;
               if (tick)
               begin
                  cnt <= cnt + 9'h001;
                  if (cnt == LOW_DRIVE_TICKS - 9'h001) // [R6]
                     state <= st_idle;
               end
            end
            default: state <= st_idle;
         endcase
      end
   end

   // Open-drain line: only ever pulls low
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         line_oe <= 1'b0;
      else
         line_oe <= ack_drive || state == st_low_drive; // [R6]
   end

   assign line_out = 1'b0;

endmodule

// ===== rx_timing_ctrl_asserts.sv
// Concurrent checks on the ports of the receive timing block.
// Assumes one AHB-Lite master, hready looped back from hreadyout, one clock.
`timescale 1ns/10ps
module rx_timing_ctrl_asserts
   import rx_timing_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic frame_start,
   input wire logic line_in,
   input wire logic line_out,
   input wire logic line_oe,
   input wire logic irq
);
   // ==========================================================
   // Shadow state
   localparam int OE_MIN = 27 * int'(TICK_DIV);
   localparam int OE_MAX = 120 * int'(TICK_DIV);
   logic addr_ph;
   logic rd_req;
   logic wr_ctrl;
   logic wr_mask;
   logic [31:0] ctrl_sh;
   logic [2:0] mask_sh;
   logic [31:0] oe_len;
   logic [2:0] low_run;
   assign addr_ph = hsel && hready && htrans[1];
   assign rd_req = addr_ph && !hwrite;

   // Mirror of the control and mask registers; a write lands at the end of its data phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_ctrl <= 1'b0;
         wr_mask <= 1'b0;
         ctrl_sh <= 32'h0;
         mask_sh <= 3'h0;
      end
      else
      begin
         wr_ctrl <= addr_ph && hwrite && haddr == {24'h0, CTRL_ADDR};
         wr_mask <= addr_ph && hwrite && haddr == {24'h0, MASK_ADDR};
         if (wr_ctrl)
            ctrl_sh <= hwdata & 32'h0137_777f;
         if (wr_mask)
            mask_sh <= hwdata[2:0];
      end
   end

   // Length of each low drive and of the low run seen on the line
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         oe_len <= 32'h0;
         low_run <= 3'h0;
      end
      else
      begin
         oe_len <= line_oe ? oe_len + 32'h1 : 32'h0;
         if (line_in)
            low_run <= 3'h0;
         else if (low_run != 3'h7)
            low_run <= low_run + 3'h1;
      end
   end

   // ==========================================================
   // Properties
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_ctrl_read;
      rd_req && !wr_ctrl && haddr == {24'h0, CTRL_ADDR};
   endsequence
   sequence s_mask_read;
      rd_req && !wr_mask && haddr == {24'h0, MASK_ADDR};
   endsequence
   property p_ctrl_readback;
      s_ctrl_read |=> hrdata == ctrl_sh;
   endproperty
   property p_mask_readback;
      s_mask_read |=> hrdata == {29'h0, mask_sh};
   endproperty
   property p_unmapped_zero;
      rd_req && haddr > 32'h10 |=> hrdata == 32'h0;
   endproperty
   property p_rdata_holds;
      !$past(rd_req) |-> $stable(hrdata);
   endproperty
   property p_bus_okay;
      hreadyout && !hresp;
   endproperty
   property p_irq_masked;
      mask_sh == 3'h0 && $past(mask_sh) == 3'h0 |-> !irq;
   endproperty
   property p_open_drain;
      !line_out;
   endproperty
   property p_drive_len;
      $fell(line_oe) |-> oe_len >= OE_MIN && oe_len <= OE_MAX;
   endproperty
   property p_drive_after_fall;
      $rose(line_oe) |-> low_run >= 3'h3;
   endproperty

   a_ctrl_readback: assert property (p_ctrl_readback)
      else $error("control read differs from written value");
   a_mask_readback: assert property (p_mask_readback)
      else $error("mask read differs from written value");
   a_unmapped_zero: assert property (p_unmapped_zero)
      else $error("unmapped read not zero");
   a_rdata_holds: assert property (p_rdata_holds)
      else $error("read data moved without a read");
   a_bus_okay: assert property (p_bus_okay)
      else $error("wait state or error response");
   a_irq_masked: assert property (p_irq_masked)
      else $error("interrupt with all sources masked");
   a_open_drain: assert property (p_open_drain)
      else $error("line driven high");
   a_drive_len: assert property (p_drive_len)
      else $error("low drive length out of range");
   a_drive_after_fall: assert property (p_drive_after_fall)
      else $error("low drive started without a falling edge");
endmodule

bind rx_timing_ctrl rx_timing_ctrl_asserts chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
   .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .frame_start(frame_start), .line_in(line_in), .line_out(line_out), .line_oe(line_oe),
   .irq(irq));

// ===== rx_timing_ctrl_tb.sv
// Self-checking bench for the receive timing block: registers and short-cycle error.
// Assumes the block is the only bus slave and the line has one other talker.
`timescale 1ns/10ps
`define CHK(got, exp) \
   begin \
      n_tests++; \
      if ((got) !== (exp)) \
      begin \
         fails++; \
         $display("FAIL %0t got %h expected %h", $time, (got), (exp)); \
      end \
   end
module rx_timing_ctrl_tb
   import rx_timing_pkg::*;
;
   // ==========================================================
   // Signals
   localparam int TK = int'(TICK_DIV);
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic frame_start, line_in, line_out, line_oe, irq, pull_low;
   int fails = 0;
   int n_tests = 0;
   int i, n;
   time t0;
   assign hready = hreadyout;

   rx_timing_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .frame_start(frame_start),
      .line_in(line_in), .line_out(line_out), .line_oe(line_oe), .irq(irq));
   line_peer peer (.hclk(hclk), .line_oe(line_oe), .line_out(line_out),
      .pull_low(pull_low), .line_level(line_in));

   // Clock at 25 MHz
   initial
   begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end

   // ==========================================================
   // Tasks
   task complete_run;
      $display("Comparisons %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Bounded wait for hready; a stuck bus ends the run
   task wait_ready;
      int k;
      @(posedge hclk);
      for (k = 0; k < 16 && hreadyout !== 1'b1; k++)
         @(posedge hclk);
      if (hreadyout !== 1'b1)
      begin
         fails++;
         $display("FAIL %0t bus never ready", $time);
         complete_run();
      end
   endtask

   task bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= wr;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask

   task wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask

   task check_reg(input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] x;
      bus(1'b0, a, 32'h0, x);
      `CHK(x, exp)
   endtask

   // ==========================================================
   // Main sequence
   initial
   begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      frame_start = 1'b0;
      pull_low = 1'b0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      // Reset values, unmapped word included
      for (i = 0; i <= 20; i += 4)
         check_reg(i, 32'h0);
      // Only the documented fields of the control word hold ones
      wr(CTRL_ADDR, 32'hffff_ffff);
      check_reg(CTRL_ADDR, 32'h0137_777f);
      wr(CTRL_ADDR, 32'h0000_0000);
      check_reg(CTRL_ADDR, 32'h0);
      wr(OWN_ADDR_ADDR, 32'hffff_ffff);
      check_reg(OWN_ADDR_ADDR, 32'h0000_ffff);
      wr(RXDATA_ADDR, 32'hffff_ffff);
      check_reg(RXDATA_ADDR, 32'h0);
      wr(32'h14, 32'hffff_ffff);
      check_reg(32'h14, 32'h0);
      // Bit 0 starts, then the next fall comes after 6 ticks, far under 67
      frame_start <= 1'b1;
      @(posedge hclk);
      frame_start <= 1'b0;
      pull_low <= 1'b1;
      repeat (2 * TK) @(posedge hclk);
      pull_low <= 1'b0;
      repeat (4 * TK) @(posedge hclk);
      pull_low <= 1'b1;
      for (n = 0; n < 12 * TK && line_oe !== 1'b1; n++)
         @(posedge hclk);
      t0 = $time;
      `CHK(line_oe, 1'b1)
      if (line_oe !== 1'b1)
         complete_run();
      pull_low <= 1'b0;
      repeat (8) @(posedge hclk);
      `CHK(line_in, 1'b0)
      check_reg(STATUS_ADDR, 32'h2);
      `CHK(irq, 1'b0)
      wr(MASK_ADDR, 32'h2);
      repeat (2) @(posedge hclk);
      `CHK(irq, 1'b1)
      // The drive lasts 119 ticks; allow one tick of phase either way
      for (n = 0; n < 125 * TK && line_oe === 1'b1; n++)
         @(posedge hclk);
      n = int'(($time - t0) / 40);
      `CHK(n >= 118 * TK && n <= 120 * TK, 1'b1)
      repeat (8) @(posedge hclk);
      `CHK(line_in, 1'b1)
      wr(STATUS_ADDR, 32'h2);
      repeat (2) @(posedge hclk);
      `CHK(irq, 1'b0)
      check_reg(STATUS_ADDR, 32'h0);
      complete_run();
   end
endmodule

// ===== rx_timing_pkg.sv
// Shared constants, register map and carriers for the line receiver timing block.
// Assumes a 25 MHz system clock and a sampling tick near 32.768 kHz made from it.
package rx_timing_pkg;

   // ==========================================================
   // Clock and sampling tick
   localparam int unsigned CLK_HZ = 25000000;
   localparam int unsigned SAMPLE_TICK_HZ = 32768;
   localparam logic [9:0] TICK_DIV = 10'(CLK_HZ / SAMPLE_TICK_HZ);

   // ==========================================================
   // Bit timing, in sample ticks
   localparam logic [8:0] MIN_BASE_TICKS = 9'h043;
   localparam logic [8:0] MAX_BASE_TICKS = 9'h05a;
   localparam logic [8:0] DATA_BASE_TICKS = 9'h022;
   localparam logic [8:0] DATA_STEP_TICKS = 9'h002;
   localparam int unsigned LOW_DRIVE_US = 3630;
   localparam logic [8:0] LOW_DRIVE_TICKS =
      9'((LOW_DRIVE_US * 64'd32768 + 64'd999999) / 64'd1000000);
   localparam logic [3:0] LAST_BIT = 4'h9;
   localparam logic [3:0] EOM_BIT = 4'h8;
   localparam logic [3:0] BYTE_BIT = 4'h7;
   localparam logic [2:0] MAX_FILTER_CODE = 3'h3;

   // ==========================================================
   // Register map, byte addresses
   localparam logic [7:0] CTRL_ADDR = 8'h00;
   localparam logic [7:0] OWN_ADDR_ADDR = 8'h04;
   localparam logic [7:0] STATUS_ADDR = 8'h08;
   localparam logic [7:0] MASK_ADDR = 8'h0c;
   localparam logic [7:0] RXDATA_ADDR = 8'h10;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] CTRL_WMASK = 32'h0137_777f;
   localparam logic [15:0] OWN_ADDR_RESET = 16'h0000;
   localparam logic [2:0] STATUS_RESET = 3'h0;

   // Status and mask bit positions
   localparam int unsigned ST_RX_BYTE = 0;
   localparam int unsigned ST_MIN_ERR = 1;
   localparam int unsigned ST_MAX_ERR = 2;

   // ==========================================================
   // Control register fields
   typedef struct packed {
      logic data_ack_suppress;
      logic [1:0] high_glitch_filter_len;
      logic [2:0] low_glitch_filter_len;
      logic [2:0] min_bit_cycle_adjust;
      logic [2:0] max_bit_cycle_adjust;
      logic [2:0] data_decision_point;
      logic [1:0] timeout_cycles;
      logic error_irq_hold;
      logic foreign_address_receive;
   } ctrl_s;

   // Filtered line seen by the receiver
   typedef struct packed {
      logic level;
      logic fall;
   } line_s;

   function automatic ctrl_s unpack_ctrl(input logic [31:0] r);
      ctrl_s c;
      c.data_ack_suppress = r[24];
      c.high_glitch_filter_len = r[21:20];
      c.low_glitch_filter_len = r[18:16];
      c.min_bit_cycle_adjust = r[14:12];
      c.max_bit_cycle_adjust = r[10:8];
      c.data_decision_point = r[6:4];
      c.timeout_cycles = r[3:2];
      c.error_irq_hold = r[1];
      c.foreign_address_receive = r[0];
      return c;
   endfunction

endpackage
